//--- pkg/rpm_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RPM_CONSTS_SVH
`define RPM_CONSTS_SVH
`define RPM_ADDR_W 4
`define RPM_OFF_CTRL 4'h0
`define RPM_OFF_PROT 4'h1
`define RPM_OFF_SWMODE 4'h2
`define RPM_OFF_STATUS 4'h3
`define RPM_OFF_IRQ_STAT 4'h4
`define RPM_OFF_IRQ_MASK 4'h5
`define RPM_OFF_CLEAR 4'h6
`define RPM_OFF_STATE 4'h7
`define RPM_PROT_RESET 8'h17
`define RPM_PROT_MASK 8'h3f
`define RPM_BIT_CARRIER 0
`define RPM_BIT_INPL 1
`define RPM_BIT_OUTPL 2
`define RPM_CTRL_RESET 2'h0
`define RPM_IRQ_LOCKOUT 0
`define RPM_IRQ_INPL 1
`define RPM_IRQ_OUTPL 2
`define RPM_IRQ_CLEARED 3
`define RPM_SEL_SETTLE_MS 2
`endif

//--- pkg/rpm_pkg.sv
// Types shared by the run permit and motor select block
package rpm_pkg;
    typedef enum logic [1:0] {
        RPM_MOTOR1,
        RPM_MOTOR2,
        RPM_MOTOR3,
        RPM_MOTOR4
    } rpm_motor_t;
    typedef enum logic [1:0] {
        RPM_IDLE,
        RPM_RUN,
        RPM_LOCKED,
        RPM_TRIPPED
    } rpm_state_t;
endpackage : rpm_pkg

//--- rtl/rpm_top.sv
// Run permit, protection mode and motor select logic
//
// What this block does
// RULE1 - Stop key stops terminal or serial run, then lockout
// RULE2 - Run asserted at power-up: refuse, lockout
// RULE3 - Start check on alarm reset release
// RULE4 - Start check on run source change
// RULE5 - Two-bit setting combines both features
// RULE6 - Writing one clears history, self-returns zero
// RULE7 - Keypad clear needs two keys together
// RULE8 - Protection word resets to hex 17
// RULE9 - Bit 0 lowers carrier on overheat; here only while VF_CONTROL is high
// RULE10 - Bit 1 trips on input phase loss
// RULE11 - Bit 2 trips on output phase loss
// RULE12 - Four parameter groups, selected one drives
// RULE13 - Mode 0 motor switch, 1 parameters
// RULE14 - Parameter mode may switch while running
// RULE15 - Priority select, one active output
// RULE16 - Motor mode switches only when stopped
// RULE17 - Selection settles 2 ms before run; this block does not time it and takes a run at once
// RULE18 - Lockout holds until all runs removed
// RULE19 - Reserved protection bits read zero
//
// Interfaces
// Register port: index, data, two strobes
// Read data stand one cycle after the strobe
// Run sources: keypad, terminal, serial link
// Keys: stop, reset, two clear keys
// Detectors arrive as outside levels
// Every pin input except the register port and reset passes two flip-flops
// Motor outputs are one-hot
// Outputs come straight from flip-flops
`timescale 1ns/1ps
`include "rpm_consts.svh"
module rpm_top (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [`RPM_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic RUN_KEYPAD,
    input wire logic RUN_TERMINAL,
    input wire logic RUN_SERIAL,
    input wire logic STOP_KEY,
    input wire logic RESET_KEY,
    input wire logic CLEAR_KEY_A,
    input wire logic CLEAR_KEY_B,
    input wire logic ALARM_RESET_INPUT,
    input wire logic SERIAL_LINK_ENABLE_INPUT,
    input wire logic LOCAL_OPERATION_INPUT,
    input wire logic VF_CONTROL,
    input wire logic HEATSINK_OVERHEAT_ALARM,
    input wire logic INTERNAL_OVERHEAT_ALARM,
    input wire logic DRIVE_OVERLOAD_ALARM,
    input wire logic INPUT_PHASE_LOSS,
    input wire logic OUTPUT_PHASE_LOSS,
    input wire logic SELECT_SECOND_MOTOR_INPUT,
    input wire logic SELECT_THIRD_MOTOR_INPUT,
    input wire logic SELECT_FOURTH_MOTOR_INPUT,
    output logic RUN_ENABLE,
    output logic DECEL_STOP,
    output logic RUN_LOCKOUT_ALARM,
    output logic INPUT_PHASE_LOSS_ALARM,
    output logic OUTPUT_PHASE_LOSS_ALARM,
    output logic OVERHEAT_TRIP,
    output logic LOWER_CARRIER,
    output logic HISTORY_CLEAR,
    output rpm_pkg::rpm_motor_t ACTIVE_GROUP,
    output logic FIRST_MOTOR_ACTIVE_OUTPUT,
    output logic SECOND_MOTOR_ACTIVE_OUTPUT,
    output logic THIRD_MOTOR_ACTIVE_OUTPUT,
    output logic FOURTH_MOTOR_ACTIVE_OUTPUT,
    output logic IRQ
);
    import rpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NIN = 17;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;

    // Seventeen pins share one synchroniser bus;
    // motor 4 select and V/f use a second pair
    assign raw_in = {RUN_KEYPAD, RUN_TERMINAL, RUN_SERIAL, STOP_KEY, RESET_KEY,
                     CLEAR_KEY_A, CLEAR_KEY_B, ALARM_RESET_INPUT,
                     SERIAL_LINK_ENABLE_INPUT, LOCAL_OPERATION_INPUT,
                     HEATSINK_OVERHEAT_ALARM, INTERNAL_OVERHEAT_ALARM,
                     DRIVE_OVERLOAD_ALARM, INPUT_PHASE_LOSS, OUTPUT_PHASE_LOSS,
                     SELECT_SECOND_MOTOR_INPUT, SELECT_THIRD_MOTOR_INPUT};
    logic [1:0] sel_s1_q;
    logic [1:0] sel_s2_q;

    // No reset: the pins are sampled through reset,
    // so the power-up check sees the real run levels
    always_ff @(posedge CLK_SYS) begin
        sync1_q <= raw_in;
        sync2_q <= sync1_q;
        sel_s1_q <= {SELECT_FOURTH_MOTOR_INPUT, VF_CONTROL};
        sel_s2_q <= sel_s1_q;
    end
    wire run_kp = sync2_q[16];
    wire run_tm = sync2_q[15];
    wire run_sl = sync2_q[14];
    wire stop_key = sync2_q[13];
    wire reset_key = sync2_q[12];
    wire key_a = sync2_q[11];
    wire key_b = sync2_q[10];
    wire alm_rst = sync2_q[9];
    wire link_en = sync2_q[8];
    wire local_op = sync2_q[7];
    wire oh_heatsink = sync2_q[6];
    wire oh_internal = sync2_q[5];
    wire overload = sync2_q[4];
    wire in_loss = sync2_q[3];
    wire out_loss = sync2_q[2];
    wire sel2 = sync2_q[1];
    wire sel3 = sync2_q[0];
    wire sel4 = sel_s2_q[1];
    wire vf_ctl = sel_s2_q[0];

    // Synchronised levels
    // Runs: run_kp, run_tm, run_sl
    // Keys: stop_key, reset_key, key_a, key_b
    // Source: link_en, local_op
    // Heat: oh_heatsink, oh_internal, overload
    // Loss: in_loss, out_loss
    // Select: sel2, sel3, sel4

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [1:0] ctrl_q;
    logic [7:0] prot_q;
    logic [2:0] swmode_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic clear_q;

    // Register map
    // 0 setting, 1 protection, 2 switch modes
    // 3 status, 4 event status, 5 event mask
    // 6 history clear, 7 state
    // Index 6 reads zero, the bit self-returns
    // Writes to read-only indices are ignored
    wire wr_ctrl = WR && (ADDR == `RPM_OFF_CTRL);
    wire wr_prot = WR && (ADDR == `RPM_OFF_PROT);
    wire wr_sw = WR && (ADDR == `RPM_OFF_SWMODE);
    wire wr_istat = WR && (ADDR == `RPM_OFF_IRQ_STAT);
    wire wr_imask = WR && (ADDR == `RPM_OFF_IRQ_MASK);
    wire wr_clear = WR && (ADDR == `RPM_OFF_CLEAR) && WDATA[0]; // [RULE6]
    wire key_clear_d;
    logic key_clear_q;
    assign key_clear_d = key_a && key_b; // [RULE7]
    wire key_clear_rise = key_clear_d && !key_clear_q;
    wire clear_req = wr_clear || key_clear_rise;
    // Setting 0/1 check on, 1/3 stop priority on
    wire stop_prio = ctrl_q[0]; // [RULE5]
    wire start_chk = ~ctrl_q[1]; // [RULE5]

    // Setting 0: start check only
    // Setting 1: both features
    // Setting 2: neither feature
    // Setting 3: stop priority only

    ////////////////////////////////////////////////////////////////////////////
    // Run permit state machine
    rpm_state_t state_q;
    rpm_state_t state_d;
    logic link_en_q;
    logic local_op_q;
    logic alm_rst_q;
    logic reset_key_q;
    logic pwr_chk_q;
    wire any_run = run_kp || run_tm || run_sl;
    wire src_change = (link_en != link_en_q) || (local_op != local_op_q);
    wire alarm_release = (alm_rst && !alm_rst_q) || (reset_key && !reset_key_q);
    wire in_trip = prot_q[`RPM_BIT_INPL] && in_loss; // [RULE10]
    wire out_trip = prot_q[`RPM_BIT_OUTPL] && out_loss && (state_q == RPM_RUN); // [RULE11]
    wire heat_evt = oh_heatsink || oh_internal || overload;
    wire lower_cr = prot_q[`RPM_BIT_CARRIER] && vf_ctl && heat_evt; // [RULE9]
    wire heat_trip = heat_evt && !lower_cr;
    wire chk_evt = pwr_chk_q || src_change || alarm_release; // [RULE2] [RULE3] [RULE4]
    wire chk_lock = start_chk && chk_evt && any_run;
    wire stop_lock = stop_prio && stop_key && (run_tm || run_sl) && (state_q == RPM_RUN); // [RULE1]
    wire lock_evt = (state_q != RPM_LOCKED) && (chk_lock || stop_lock);

    // Check events: power-up, alarm release,
    // source change; a held run is refused

    // Lockout leaves only once every run is gone,
    // so a held run can never restart the drive
    // Trips outrank the lockout while running

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RPM_IDLE: begin
                if (chk_lock) state_d = RPM_LOCKED;
                else if (in_trip || heat_trip) state_d = RPM_TRIPPED;
                else if (any_run && !pwr_chk_q) state_d = RPM_RUN;
            end
            RPM_RUN: begin
                if (in_trip || out_trip || heat_trip) state_d = RPM_TRIPPED;
                else if (stop_lock || chk_lock) state_d = RPM_LOCKED;
                else if (stop_key && run_kp) state_d = RPM_IDLE;
                else if (!any_run) state_d = RPM_IDLE;
            end
            RPM_LOCKED: begin
                if (!any_run) state_d = RPM_IDLE; // [RULE18]
            end
            RPM_TRIPPED: begin
                if (alarm_release) state_d = (start_chk && any_run) ? RPM_LOCKED : RPM_IDLE; // [RULE3]
            end
        endcase
    end

    // Power-up flag is high through reset and for the first cycle after it
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_q <= RPM_IDLE;
            pwr_chk_q <= 1'b1;
            link_en_q <= 1'b0;
            local_op_q <= 1'b0;
            alm_rst_q <= 1'b0;
            reset_key_q <= 1'b0;
            key_clear_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pwr_chk_q <= 1'b0;
            link_en_q <= link_en;
            local_op_q <= local_op;
            alm_rst_q <= alm_rst;
            reset_key_q <= reset_key;
            key_clear_q <= key_clear_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Motor and parameter group selection
    rpm_motor_t req_motor;
    rpm_motor_t group_q;
    assign req_motor = sel2 ? RPM_MOTOR2 : sel3 ? RPM_MOTOR3 :
                       sel4 ? RPM_MOTOR4 : RPM_MOTOR1; // [RULE15]
    // Parameter mode of both groups lets the change through while running
    wire cur_param = (group_q != RPM_MOTOR1) && swmode_q[group_q - 2'h1];
    wire req_param = (req_motor != RPM_MOTOR1) && swmode_q[req_motor - 2'h1]; // [RULE13]
    wire stopped = (state_q != RPM_RUN) && !any_run;
    wire may_switch = stopped || (cur_param && (req_param || req_motor == RPM_MOTOR1)) ||
                      (req_param && group_q == RPM_MOTOR1); // [RULE14] [RULE16]

    // Motor 1 has no mode bit and pairs with either
    // A blocked request waits until the drive stops
    logic [3:0] motor_oh;
    logic [3:0] motor_oh_q;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_oh
            assign motor_oh[gi] = (group_q == rpm_motor_t'(gi)); // [RULE15]
        end
    endgenerate

    // One-hot outputs trail the group by a cycle
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            group_q <= RPM_MOTOR1;
            motor_oh_q <= 4'h1;
        end else begin
            if (may_switch) group_q <= req_motor; // [RULE12]
            motor_oh_q <= motor_oh;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and interrupt status
    logic [3:0] irq_evt;
    assign irq_evt = {clear_req, in_trip && state_q != RPM_TRIPPED,
                      out_trip, lock_evt};

    // Events: 0 lockout, 1 output loss, 2 input loss,
    // 3 history cleared; an event wins over a clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ctrl_q <= `RPM_CTRL_RESET;
            prot_q <= `RPM_PROT_RESET; // [RULE8]
            swmode_q <= 3'h0;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
            clear_q <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= WDATA[1:0];
            if (wr_prot) prot_q <= WDATA[7:0] & `RPM_PROT_MASK; // [RULE19]
            if (wr_sw) swmode_q <= WDATA[2:0];
            if (wr_imask) irq_mask_q <= WDATA[3:0];
            irq_stat_q <= (irq_stat_q & ~(wr_istat ? WDATA[3:0] : 4'h0)) | irq_evt;
            clear_q <= clear_req; // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path, one cycle latency
    logic [31:0] rd_mux;
    // Status: group, running, lockout, losses, any run
    wire [31:0] status_word = {25'h0, any_run, OUTPUT_PHASE_LOSS_ALARM,
                               INPUT_PHASE_LOSS_ALARM, RUN_LOCKOUT_ALARM,
                               state_q == RPM_RUN, group_q};
    always_comb begin
        unique case (ADDR)
            `RPM_OFF_CTRL: rd_mux = {30'h0, ctrl_q};
            `RPM_OFF_PROT: rd_mux = {24'h0, prot_q};
            `RPM_OFF_SWMODE: rd_mux = {29'h0, swmode_q};
            `RPM_OFF_STATUS: rd_mux = status_word;
            `RPM_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
            `RPM_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
            `RPM_OFF_STATE: rd_mux = {30'h0, state_q};
            default: rd_mux = 32'h0;
        endcase
    end


    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Alarms latch their cause on entry to the trip
    // and hold it until the alarm is released
    // IRQ uses the next status so it rises in step

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rdata_q <= 32'h0;
            RUN_ENABLE <= 1'b0;
            DECEL_STOP <= 1'b0;
            RUN_LOCKOUT_ALARM <= 1'b0;
            INPUT_PHASE_LOSS_ALARM <= 1'b0;
            OUTPUT_PHASE_LOSS_ALARM <= 1'b0;
            OVERHEAT_TRIP <= 1'b0;
            LOWER_CARRIER <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            rdata_q <= RD ? rd_mux : 32'h0;
            RUN_ENABLE <= (state_d == RPM_RUN);
            DECEL_STOP <= (state_q == RPM_RUN) && (state_d != RPM_RUN);
            RUN_LOCKOUT_ALARM <= (state_d == RPM_LOCKED); // [RULE18]
            if (state_d != RPM_TRIPPED) begin
                INPUT_PHASE_LOSS_ALARM <= 1'b0;
                OUTPUT_PHASE_LOSS_ALARM <= 1'b0;
                OVERHEAT_TRIP <= 1'b0;
            end else if (state_q != RPM_TRIPPED) begin
                INPUT_PHASE_LOSS_ALARM <= in_trip; // [RULE10]
                OUTPUT_PHASE_LOSS_ALARM <= out_trip; // [RULE11]
                OVERHEAT_TRIP <= heat_trip;
            end
            LOWER_CARRIER <= lower_cr; // [RULE9]
            IRQ <= |((irq_stat_q & ~(wr_istat ? WDATA[3:0] : 4'h0) | irq_evt) & irq_mask_q);
        end
    end

    // Ports taken straight from their registers
    assign RDATA = rdata_q;
    assign HISTORY_CLEAR = clear_q;
    assign ACTIVE_GROUP = group_q;
    assign FIRST_MOTOR_ACTIVE_OUTPUT = motor_oh_q[0];
    assign SECOND_MOTOR_ACTIVE_OUTPUT = motor_oh_q[1];
    assign THIRD_MOTOR_ACTIVE_OUTPUT = motor_oh_q[2];
    assign FOURTH_MOTOR_ACTIVE_OUTPUT = motor_oh_q[3];
endmodule : rpm_top

//--- verification/rpm_top_properties.sv
// Port-level assertions for the run permit and motor select block
`timescale 1ns/1ps
`include "rpm_consts.svh"
module rpm_checker (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [`RPM_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic RUN_KEYPAD,
    input wire logic RUN_TERMINAL,
    input wire logic RUN_SERIAL,
    input wire logic RUN_ENABLE,
    input wire logic DECEL_STOP,
    input wire logic RUN_LOCKOUT_ALARM,
    input wire logic INPUT_PHASE_LOSS_ALARM,
    input wire logic OUTPUT_PHASE_LOSS_ALARM,
    input wire logic HISTORY_CLEAR,
    input wire rpm_pkg::rpm_motor_t ACTIVE_GROUP,
    input wire logic FIRST_MOTOR_ACTIVE_OUTPUT,
    input wire logic SECOND_MOTOR_ACTIVE_OUTPUT,
    input wire logic THIRD_MOTOR_ACTIVE_OUTPUT,
    input wire logic FOURTH_MOTOR_ACTIVE_OUTPUT
);
    import rpm_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    wire logic any_run = RUN_KEYPAD | RUN_TERMINAL | RUN_SERIAL;
    wire logic [3:0] hot = {FOURTH_MOTOR_ACTIVE_OUTPUT, THIRD_MOTOR_ACTIVE_OUTPUT,
        SECOND_MOTOR_ACTIVE_OUTPUT, FIRST_MOTOR_ACTIVE_OUTPUT};
    a_motor_onehot: assert property ($onehot(hot))
        else $error("motor outputs not one-hot");
    a_group_follow: assert property (hot == (4'h1 << $past(ACTIVE_GROUP)))
        else $error("motor outputs do not follow group");
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read slot");
    a_clear_write: assert property (WR && ADDR == `RPM_OFF_CLEAR && WDATA[0] |=> HISTORY_CLEAR)
        else $error("history clear not pulsed");
    a_clear_single: assert property (HISTORY_CLEAR |=> !HISTORY_CLEAR)
        else $error("history clear longer than a cycle");
    a_lockout_idle: assert property (RUN_LOCKOUT_ALARM |-> !RUN_ENABLE)
        else $error("running while locked out");
    a_trip_stops: assert property (INPUT_PHASE_LOSS_ALARM || OUTPUT_PHASE_LOSS_ALARM |-> !RUN_ENABLE)
        else $error("running while tripped");
    a_stop_decel: assert property ($fell(RUN_ENABLE) |-> DECEL_STOP)
        else $error("run left without deceleration");
    a_lockout_hold: assert property (RUN_LOCKOUT_ALARM && any_run && $past(any_run)
        && $past(any_run, 2) |=> RUN_LOCKOUT_ALARM)
        else $error("lockout dropped with run held");
    a_start_cause: assert property ($rose(RUN_ENABLE) |-> $past(any_run, 3))
        else $error("start without run command");
endmodule : rpm_checker
bind rpm_top rpm_checker i_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RUN_KEYPAD(RUN_KEYPAD),
    .RUN_TERMINAL(RUN_TERMINAL), .RUN_SERIAL(RUN_SERIAL), .RUN_ENABLE(RUN_ENABLE),
    .DECEL_STOP(DECEL_STOP), .RUN_LOCKOUT_ALARM(RUN_LOCKOUT_ALARM),
    .INPUT_PHASE_LOSS_ALARM(INPUT_PHASE_LOSS_ALARM),
    .OUTPUT_PHASE_LOSS_ALARM(OUTPUT_PHASE_LOSS_ALARM), .HISTORY_CLEAR(HISTORY_CLEAR),
    .ACTIVE_GROUP(ACTIVE_GROUP), .FIRST_MOTOR_ACTIVE_OUTPUT(FIRST_MOTOR_ACTIVE_OUTPUT),
    .SECOND_MOTOR_ACTIVE_OUTPUT(SECOND_MOTOR_ACTIVE_OUTPUT),
    .THIRD_MOTOR_ACTIVE_OUTPUT(THIRD_MOTOR_ACTIVE_OUTPUT),
    .FOURTH_MOTOR_ACTIVE_OUTPUT(FOURTH_MOTOR_ACTIVE_OUTPUT));

//--- verification/rpm_far_side.sv
// Far-side model: keypad, terminal and serial run sources with motor selection
`timescale 1ns/1ps
module rpm_far_side #(
    parameter int SETTLE_CYC = 200000
) (
    input wire logic clk,
    input wire logic [2:0] run_req,
    input wire logic [2:0] sel_req,
    output logic [2:0] run_o,
    output logic [2:0] sel_o
);
    int quiet_q = 0;
    initial run_o = 3'h0;
    initial sel_o = 3'h0;
    always @(posedge clk) begin
        sel_o <= sel_req;
        quiet_q <= (sel_req != sel_o) ? 0 : ((quiet_q < SETTLE_CYC) ? quiet_q + 1 : quiet_q);
        // A run only rises once the selection has been steady long enough
        run_o <= run_req & ((quiet_q >= SETTLE_CYC) ? 3'h7 : run_o);
    end
endmodule : rpm_far_side

//--- verification/tb_top.sv
// Self-checking bench for the run permit and motor select block
`timescale 1ns/1ps
`include "rpm_consts.svh"
module tb_top;
    import rpm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [2:0] run_req = 3'h0;
    logic [2:0] sel_req = 3'h0;
    logic [2:0] run_w;
    logic [2:0] sel_w;
    logic stop_k = 1'b0;
    logic rst_k = 1'b0;
    logic [1:0] clr_k = 2'h0;
    logic alm_rst = 1'b0;
    logic src_le = 1'b0;
    logic loc_op = 1'b0;
    logic vf = 1'b0;
    logic heat = 1'b0;
    logic [1:0] loss = 2'h0;
    logic run_en, decel, lock, in_alm, out_alm, oh_trip, low_car, hclr, irq;
    logic [3:0] mot;
    rpm_motor_t grp;
    int failures = 0;
    int comparisons = 0;
    rpm_far_side #(.SETTLE_CYC(16)) i_far (.clk(clk), .run_req(run_req), .sel_req(sel_req),
        .run_o(run_w), .sel_o(sel_w));
    rpm_top i_dut (.CLK_SYS(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RUN_KEYPAD(run_w[0]), .RUN_TERMINAL(run_w[1]), .RUN_SERIAL(run_w[2]),
        .STOP_KEY(stop_k), .RESET_KEY(rst_k), .CLEAR_KEY_A(clr_k[0]), .CLEAR_KEY_B(clr_k[1]),
        .ALARM_RESET_INPUT(alm_rst), .SERIAL_LINK_ENABLE_INPUT(src_le),
        .LOCAL_OPERATION_INPUT(loc_op), .VF_CONTROL(vf), .HEATSINK_OVERHEAT_ALARM(heat),
        .INTERNAL_OVERHEAT_ALARM(1'b0), .DRIVE_OVERLOAD_ALARM(1'b0),
        .INPUT_PHASE_LOSS(loss[0]), .OUTPUT_PHASE_LOSS(loss[1]),
        .SELECT_SECOND_MOTOR_INPUT(sel_w[0]), .SELECT_THIRD_MOTOR_INPUT(sel_w[1]),
        .SELECT_FOURTH_MOTOR_INPUT(sel_w[2]), .RUN_ENABLE(run_en), .DECEL_STOP(decel),
        .RUN_LOCKOUT_ALARM(lock), .INPUT_PHASE_LOSS_ALARM(in_alm),
        .OUTPUT_PHASE_LOSS_ALARM(out_alm), .OVERHEAT_TRIP(oh_trip), .LOWER_CARRIER(low_car),
        .HISTORY_CLEAR(hclr), .ACTIVE_GROUP(grp), .FIRST_MOTOR_ACTIVE_OUTPUT(mot[0]),
        .SECOND_MOTOR_ACTIVE_OUTPUT(mot[1]), .THIRD_MOTOR_ACTIVE_OUTPUT(mot[2]),
        .FOURTH_MOTOR_ACTIVE_OUTPUT(mot[3]), .IRQ(irq));
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic cr(input logic [3:0] a, input logic [31:0] e, input string m);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata === e, m);
        @(posedge clk);
    endtask : cr
    task automatic count_clr(output int n);
        n = 0;
        repeat (8) begin
            @(posedge clk);
            if (hclr === 1'b1) n++;
        end
    endtask : count_clr
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        cr(`RPM_OFF_PROT, 32'h17, "prot reset");
        cr(`RPM_OFF_CTRL, 32'h0, "ctrl reset");
        cr(`RPM_OFF_SWMODE, 32'h0, "swmode reset");
        wreg(`RPM_OFF_PROT, 32'hff);
        cr(`RPM_OFF_PROT, 32'h3f, "reserved bits");
        cr(4'h8, 32'h0, "unmapped read");
        wreg(`RPM_OFF_PROT, 32'h17);
    endtask : t_regs
    task automatic t_source();
        for (int c = 0; c < 4; c++) begin
            wreg(`RPM_OFF_CTRL, 32'(c));
            run_req <= 3'h2;
            cyc(24);
            stop_k <= 1'b1;
            cyc(6);
            stop_k <= 1'b0;
            chk(lock === c[0], "stop priority");
            cyc(6);
            chk(lock === c[0], "lockout held");
            if (c[0]) begin
                run_req <= 3'h0;
                cyc(6);
                chk(lock === 1'b0, "lockout release");
                run_req <= 3'h2;
                cyc(24);
            end
            chk(run_en === 1'b1, "fresh start");
            if (c[1]) loc_op <= ~loc_op;
            else src_le <= ~src_le;
            cyc(6);
            chk(lock === (c < 2), "source change");
            run_req <= 3'h0;
            cyc(6);
        end
        wreg(`RPM_OFF_CTRL, 32'h0);
    endtask : t_source
    task automatic t_protect();
        run_req <= 3'h1;
        vf <= 1'b1;
        cyc(24);
        heat <= 1'b1;
        cyc(6);
        chk(low_car === 1'b1 && oh_trip === 1'b0 && run_en === 1'b1, "carrier");
        heat <= 1'b0;
        wreg(`RPM_OFF_PROT, 32'h11);
        loss <= 2'h3;
        cyc(6);
        chk(run_en === 1'b1 && in_alm === 1'b0 && out_alm === 1'b0, "loss off");
        loss <= 2'h0;
        cyc(4);
        wreg(`RPM_OFF_PROT, 32'h17);
        loss <= 2'h2;
        cyc(6);
        chk(out_alm === 1'b1 && run_en === 1'b0, "output loss");
        loss <= 2'h0;
        alm_rst <= 1'b1;
        cyc(6);
        chk(lock === 1'b1, "reset check");
        alm_rst <= 1'b0;
        run_req <= 3'h0;
        cyc(6);
        loss <= 2'h1;
        cyc(6);
        chk(in_alm === 1'b1, "input loss");
        loss <= 2'h0;
        rst_k <= 1'b1;
        cyc(6);
        rst_k <= 1'b0;
        chk(in_alm === 1'b0 && lock === 1'b0, "trip released");
    endtask : t_protect
    task automatic t_motor();
        logic [2:0] sv [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
        rpm_motor_t gv [4] = '{RPM_MOTOR2, RPM_MOTOR3, RPM_MOTOR4, RPM_MOTOR1};
        for (int i = 0; i < 4; i++) begin
            sel_req <= sv[i];
            cyc(6);
            chk(grp === gv[i] && mot === (4'h1 << gv[i]), "priority");
        end
        run_req <= 3'h2;
        cyc(24);
        sel_req <= 3'h1;
        cyc(8);
        chk(run_en === 1'b1 && grp === RPM_MOTOR1, "switch held");
        run_req <= 3'h0;
        cyc(6);
        chk(grp === RPM_MOTOR2, "switch stopped");
        wreg(`RPM_OFF_SWMODE, 32'h7);
        run_req <= 3'h2;
        cyc(24);
        sel_req <= 3'h2;
        cyc(6);
        chk(run_en === 1'b1 && grp === RPM_MOTOR3, "param switch");
        run_req <= 3'h0;
        sel_req <= 3'h0;
        cyc(6);
    endtask : t_motor
    task automatic t_power();
        run_req <= 3'h1;
        cyc(24);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(6);
        chk(lock === 1'b1 && run_en === 1'b0, "power-up check");
        run_req <= 3'h0;
        cyc(6);
        chk(lock === 1'b0, "power-up release");
    endtask : t_power
    task automatic t_clear();
        int n;
        wreg(`RPM_OFF_IRQ_STAT, 32'hf);
        wreg(`RPM_OFF_IRQ_MASK, 32'h8);
        wreg(`RPM_OFF_CLEAR, 32'h0);
        count_clr(n);
        chk(n == 0 && irq === 1'b0, "write zero");
        wreg(`RPM_OFF_CLEAR, 32'h1);
        count_clr(n);
        chk(n == 1 && irq === 1'b1, "write one");
        cr(`RPM_OFF_CLEAR, 32'h0, "self return");
        cr(`RPM_OFF_IRQ_STAT, 32'h8, "status bit");
        wreg(`RPM_OFF_IRQ_STAT, 32'h8);
        cyc(2);
        chk(irq === 1'b0, "irq cleared");
        clr_k <= 2'h1;
        count_clr(n);
        chk(n == 0, "one key");
        clr_k <= 2'h3;
        count_clr(n);
        chk(n == 1 && irq === 1'b1, "two keys");
        clr_k <= 2'h0;
        wreg(`RPM_OFF_IRQ_MASK, 32'h0);
        cyc(2);
        chk(irq === 1'b0, "irq masked");
    endtask : t_clear
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_source();
        t_protect();
        t_motor();
        t_power();
        t_clear();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule : tb_top
